// ===== core/spd_core.sv
// stepper profile and drive control: apb registers, ramp sequencer, driver chip controls
//
// Notes on behaviour
// - resolution 0 whole..3 sixteenth, default sixteenth
// - decay 0 slow, 1 fast, 2 mixed; default mixed
// - decay acts only on falling phase current
// - mixed: fast then slow within off-time
// - accel from standstill, decel on full stop
// - running rate changes apply at once
// - accel stops at lower commanded rate
// - five stored profiles of time/velocity entries
// - stop starts decel at matching profile point
// - overspeed stop drops to profile maximum first
// - profile 0 none, jump directly; 1-5 stored
// - sleep value one or more sleeps driver
// - after sleep, running transition or command change wakes
// - reset disables, stops, homes the microstep
// - after reset, running transition or change re-enables
// - sleep/reset booleans with 0.0/1.0 thresholds
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module spd_core
    import spd_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    output var  logic [1:0]        res_sel,
    output var  logic [1:0]        decay_select_level,
    output var  logic              drv_enable_n,
    output var  logic              drv_sleep_n,
    output var  logic              drv_reset_n,
    output var  logic              drv_dir,
    output var  logic [RATE_W-1:0] step_rate
);
    typedef struct packed {
        logic [1:0]          res;
        logic [1:0]          decay;
        logic [SEL_W-1:0]    prof;
        logic [3:0]          mode;
        logic                dir;
        logic [RATE_W-1:0]   cmd_rate;
        logic signed [31:0]  sleep_val;
        logic signed [31:0]  reset_val;
        logic                sleep_on;
        logic                reset_on;
        logic                blocked;
        logic [TBL_ADDR_W-1:0] tbl_addr;
        spd_state_type       state;
        logic [IDX_W-1:0]    idx;
        logic                seek;
        logic [TIME_W-1:0]   elapsed;
        logic [RATE_W-1:0]   rate;
        logic [31:0]         rdata;
    } spd_state_rec_type;
    spd_state_rec_type s_reg, s_next;

    logic tick;
    logic tbl_wr;
    logic [TIME_W-1:0] ent_time;
    logic [RATE_W-1:0] ent_rate;
    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic start_run;
    logic stop_run;
    logic cmd_change;

    // boolean from a received signed 16.16 value with hysteresis
    function automatic logic to_bool(input logic prev, input logic signed [31:0] v);
        logic r;
        r = prev;
        if (v >= BOOL_ON_TH) begin
            r = 1'b1;
        end else if (v <= BOOL_OFF_TH) begin
            r = 1'b0;
        end
        return r;
    endfunction

    function automatic logic addr_valid(input logic [11:0] a);
        return (a <= ADDR_TBL_DATA) && (a[1:0] == 2'h0);
    endfunction

    spd_tick #(
        .CYCLES (TICK_DIV)
    ) u_tick (
        .mclk    (mclk),
        .resetn  (resetn),
        .restart (start_run || stop_run),
        .tick    (tick)
    );

    spd_table u_table (
        .mclk    (mclk),
        .wr_en   (tbl_wr),
        .wr_addr (s_reg.tbl_addr),
        .wr_data (pwdata[ENTRY_W-1:0]),
        .rd_prof (s_reg.prof),
        .rd_idx  (s_reg.idx),
        .rd_time (ent_time),
        .rd_rate (ent_rate)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // apb access: zero wait, slverr on unmapped or misaligned address
    assign pready  = 1'b1;
    assign addr_ok = addr_valid(paddr);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_acc  = psel && penable && pwrite && addr_ok;
    assign rd_acc  = psel && !penable && !pwrite && addr_ok;
    assign tbl_wr  = wr_acc && (paddr == ADDR_TBL_DATA);
    assign prdata  = s_reg.rdata;

    // running transition from host mode codes
    assign start_run = wr_acc && paddr == ADDR_CTRL
                       && pwdata[CTRL_MODE_LSB+:4] == MODE_RUNNING && s_reg.mode != MODE_RUNNING;
    assign stop_run  = wr_acc && paddr == ADDR_CTRL
                       && pwdata[CTRL_MODE_LSB+:4] != MODE_RUNNING && s_reg.mode == MODE_RUNNING;
    assign cmd_change = wr_acc && ((paddr == ADDR_RATE && pwdata[RATE_W-1:0] != s_reg.cmd_rate)
                       || (paddr == ADDR_CTRL && (pwdata[CTRL_RES_LSB+:2] != s_reg.res
                       || pwdata[CTRL_DEC_LSB+:2] != s_reg.decay || pwdata[CTRL_PROF_LSB+:SEL_W] != s_reg.prof
                       || pwdata[CTRL_DIR_BIT] != s_reg.dir)));

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        // register writes
        if (wr_acc) begin
            if (paddr == ADDR_CTRL) begin
                s_next.res   = pwdata[CTRL_RES_LSB+:2];
                s_next.decay = (pwdata[CTRL_DEC_LSB+:2] > DEC_MIXED) ? s_reg.decay : pwdata[CTRL_DEC_LSB+:2];
                s_next.prof  = (32'(pwdata[CTRL_PROF_LSB+:SEL_W]) > PROF_COUNT) ? s_reg.prof
                               : pwdata[CTRL_PROF_LSB+:SEL_W];
                s_next.mode  = pwdata[CTRL_MODE_LSB+:4];
                s_next.dir   = pwdata[CTRL_DIR_BIT];
            end else if (paddr == ADDR_RATE) begin
                s_next.cmd_rate = pwdata[RATE_W-1:0];
            end else if (paddr == ADDR_SLEEP) begin
                s_next.sleep_val = pwdata;
            end else if (paddr == ADDR_RESET) begin
                s_next.reset_val = pwdata;
            end else if (paddr == ADDR_TBL_ADDR) begin
                s_next.tbl_addr = pwdata[TBL_ADDR_W-1:0];
            end else if (paddr == ADDR_TBL_DATA) begin
                s_next.tbl_addr = s_reg.tbl_addr + TBL_ADDR_W'(1);
            end
        end
        s_next.sleep_on = to_bool(s_reg.sleep_on, s_reg.sleep_val);
        s_next.reset_on = to_bool(s_reg.reset_on, s_reg.reset_val);
        // a sleep or reset blocks the drive until a fresh start or command change
        if (s_reg.sleep_on || s_reg.reset_on) begin
            s_next.blocked = 1'b1;
        end else if (start_run || cmd_change) begin
            s_next.blocked = 1'b0;
        end

        // ramp sequencer
        case (s_reg.state)
            SPD_IDLE: begin
                s_next.rate = '0;
                if (s_reg.mode == MODE_RUNNING && !s_reg.blocked && !s_reg.reset_on) begin
                    s_next.elapsed = '0;
                    s_next.idx = '0;
                    if (s_reg.prof == RAMP_NONE) begin
                        s_next.rate  = s_reg.cmd_rate;
                        s_next.state = SPD_RUN;
                    end else begin
                        s_next.state = SPD_ACCEL;
                    end
                end
            end
            SPD_ACCEL: begin
                if (tick) begin
                    s_next.elapsed = s_reg.elapsed + TIME_W'(1);
                end
                if (s_reg.elapsed >= ent_time) begin
                    if (ent_rate >= s_reg.cmd_rate || 32'(s_reg.idx) == PROF_ENTRIES - 1) begin
                        s_next.rate  = s_reg.cmd_rate;
                        s_next.state = SPD_RUN;
                    end else begin
                        s_next.rate = ent_rate;
                        s_next.idx  = s_reg.idx + IDX_W'(1);
                    end
                end
            end
            SPD_RUN: begin
                s_next.rate = s_reg.cmd_rate;
            end
            SPD_DECEL: begin
                // seek costs one cycle per entry, cheaper than comparing the whole table at once
                if (s_reg.seek) begin
                    if (ent_rate >= s_reg.rate || 32'(s_reg.idx) == PROF_ENTRIES - 1) begin
                        s_next.seek    = 1'b0;
                        s_next.elapsed = ent_time;
                        s_next.idx     = (s_reg.idx == '0) ? s_reg.idx : s_reg.idx - IDX_W'(1);
                        if (ent_rate < s_reg.rate) begin
                            s_next.rate = ent_rate;
                        end
                    end else begin
                        s_next.idx = s_reg.idx + IDX_W'(1);
                    end
                end else begin
                    if (tick && s_reg.elapsed != '0) begin
                        s_next.elapsed = s_reg.elapsed - TIME_W'(1);
                    end
                    if (s_reg.elapsed <= ent_time) begin
                        if (s_reg.idx == '0) begin
                            s_next.rate  = '0;
                            s_next.state = SPD_IDLE;
                        end else begin
                            s_next.rate = ent_rate;
                            s_next.idx  = s_reg.idx - IDX_W'(1);
                        end
                    end
                end
            end
            default: begin
                s_next.state = SPD_IDLE;
            end
        endcase

        // stop: find the matching point, count mirrored time from there
        if (s_reg.state != SPD_IDLE && s_reg.mode != MODE_RUNNING) begin
            if (s_reg.prof == RAMP_NONE || s_reg.state == SPD_DECEL) begin
                if (s_reg.prof == RAMP_NONE) begin
                    s_next.rate  = '0;
                    s_next.state = SPD_IDLE;
                end
            end else begin
                s_next.state = SPD_DECEL;
                s_next.idx = '0;
                s_next.seek = 1'b1;
            end
        end
        // sleep or reset stops the motor at once and restarts the sequencer from idle
        if (s_reg.sleep_on || s_reg.reset_on) begin
            s_next.state = SPD_IDLE;
            s_next.rate  = '0;
        end

        // read data captured in the setup phase
        if (rd_acc) begin
            if (paddr == ADDR_CTRL) begin
                s_next.rdata = 32'({s_reg.dir, s_reg.mode, 1'b0, s_reg.prof, s_reg.decay, s_reg.res});
            end else if (paddr == ADDR_RATE) begin
                s_next.rdata = 32'(s_reg.cmd_rate);
            end else if (paddr == ADDR_SLEEP) begin
                s_next.rdata = s_reg.sleep_val;
            end else if (paddr == ADDR_RESET) begin
                s_next.rdata = s_reg.reset_val;
            end else if (paddr == ADDR_STATUS) begin
                s_next.rdata = 32'({s_reg.blocked, s_reg.reset_on, s_reg.sleep_on, s_reg.state});
            end else if (paddr == ADDR_CUR_RATE) begin
                s_next.rdata = 32'(s_reg.rate);
            end else if (paddr == ADDR_TBL_ADDR) begin
                s_next.rdata = 32'(s_reg.tbl_addr);
            end else begin
                s_next.rdata = 32'h0;
            end
        end
    end

    // decel counts the matching entry's time down one ms per tick, stepping entries downward;
    // the overspeed hold comes from the top entries sharing the maximum velocity
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_reg       <= '0;
            s_reg.res   <= RES_SIXTEEN;
            s_reg.decay <= DEC_MIXED;
            s_reg.prof  <= RAMP_NONE;
            s_reg.mode  <= MODE_STOPPED;
            s_reg.dir   <= 1'b1;
            s_reg.state <= SPD_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // driver chip controls; the chip applies decay only on falling current steps
    // and splits mixed decay into fast then slow by its own off-time network
    assign res_sel            = s_reg.res;
    assign decay_select_level = s_reg.decay;
    assign drv_sleep_n        = !s_reg.sleep_on;
    assign drv_reset_n        = !s_reg.reset_on;
    assign drv_enable_n       = s_reg.blocked || s_reg.sleep_on || s_reg.reset_on;
    assign drv_dir            = s_reg.dir;
    assign step_rate          = s_reg.rate;

    ////////////////////////////////////////////////////////////////////////////////
    chk_reset_default: assert property (@(posedge mclk) $rose(resetn) |-> res_sel == RES_SIXTEEN
        && decay_select_level == DEC_MIXED) else $error("reset defaults wrong");
    chk_sleep_disable: assert property (@(posedge mclk) disable iff (!resetn)
        s_reg.sleep_on |-> !drv_sleep_n ##1 (drv_enable_n && step_rate == '0)) else $error("sleep not disabling");
    chk_sleep_hold: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(s_reg.sleep_on) |-> drv_enable_n) else $error("woke without trigger");
    chk_reset_stop: assert property (@(posedge mclk) disable iff (!resetn)
        s_reg.reset_on |=> step_rate == '0) else $error("rate not zero in reset");
    chk_reset_release: assert property (@(posedge mclk) disable iff (!resetn)
        s_reg.blocked && !s_reg.sleep_on && !s_reg.reset_on && start_run |=> !drv_enable_n)
        else $error("start did not re-enable");
    chk_bool_thresh: assert property (@(posedge mclk) disable iff (!resetn)
        s_reg.sleep_val >= BOOL_ON_TH |=> s_reg.sleep_on) else $error("sleep threshold");
    chk_no_ramp: assert property (@(posedge mclk) disable iff (!resetn)
        s_reg.state == SPD_RUN && s_reg.mode == MODE_RUNNING && !s_reg.sleep_on && !s_reg.reset_on
        |=> step_rate == $past(s_reg.cmd_rate)) else $error("run rate not immediate");
    chk_direct_jump: assert property (@(posedge mclk) disable iff (!resetn)
        s_reg.state == SPD_IDLE && s_reg.prof == RAMP_NONE && s_reg.mode == MODE_RUNNING
        && !s_reg.blocked && !s_reg.reset_on && !s_reg.sleep_on |=> step_rate == $past(s_reg.cmd_rate))
        else $error("no-profile start not direct");
    chk_accel_cap: assert property (@(posedge mclk) disable iff (!resetn)
        s_reg.state == SPD_ACCEL |-> step_rate <= s_reg.cmd_rate || $changed(s_reg.cmd_rate))
        else $error("accel overshoot");
    cov_accel: cover property (@(posedge mclk) s_reg.state == SPD_ACCEL ##1 s_reg.state == SPD_RUN);
    cov_decel: cover property (@(posedge mclk) s_reg.state == SPD_DECEL ##1 s_reg.state == SPD_IDLE);
    cov_sleep: cover property (@(posedge mclk) $fell(s_reg.sleep_on));
endmodule
`default_nettype wire

// ===== core/spd_table.sv
// profile table memory: five profiles of time and velocity entries
`timescale 1ns/1ps
`default_nettype none
module spd_table
    import spd_pkg::*;
#(
    parameter int unsigned NPROF = PROF_COUNT,
    parameter int unsigned NENT  = PROF_ENTRIES
) (
    input  wire logic                  mclk,
    input  wire logic                  wr_en,
    input  wire logic [TBL_ADDR_W-1:0] wr_addr,
    input  wire logic [ENTRY_W-1:0]    wr_data,
    input  wire logic [SEL_W-1:0]      rd_prof,
    input  wire logic [IDX_W-1:0]      rd_idx,
    output var  logic [TIME_W-1:0]     rd_time,
    output var  logic [RATE_W-1:0]     rd_rate
);
    // flat array, profile p entry i at p*NENT+i; profile 1 sits at p=0
    logic [ENTRY_W-1:0] mem [NPROF*NENT];
    logic [TBL_ADDR_W-1:0] ra;

    always_ff @(posedge mclk) begin
        if (wr_en && (wr_addr < TBL_ADDR_W'(NPROF*NENT))) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // unselected profile reads as zero; async read keeps the sequencer one cycle shorter
    always_comb begin
        ra = TBL_ADDR_W'((32'(rd_prof) - 32'h1) * NENT + 32'(rd_idx));
        if (rd_prof == RAMP_NONE || 32'(rd_prof) > NPROF) begin
            rd_time = '0;
            rd_rate = '0;
        end else begin
            rd_time = mem[ra][ENTRY_W-1:RATE_W];
            rd_rate = mem[ra][RATE_W-1:0];
        end
    end
endmodule
`default_nettype wire

// ===== core/spd_tick.sv
// millisecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none
module spd_tick
    import spd_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic restart,
    output var  logic tick
);
    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } spd_tick_state_type;
    spd_tick_state_type s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (restart) begin
            s_next.count = 32'h0;
        end else if (s_reg.count == CYCLES - 1) begin
            s_next.count = 32'h0;
            s_next.tick = 1'b1;
        end else begin
            s_next.count = s_reg.count + 32'h1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign tick = s_reg.tick;
endmodule
`default_nettype wire

// ===== shared/spd_pkg.sv
// package: constants and types for the stepper profile and drive control block
package spd_pkg;
    localparam int unsigned CLK_HZ         = 50000000;
    localparam int unsigned TICK_MS        = 1;
    localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned PROF_COUNT     = 5;
    localparam int unsigned PROF_ENTRIES   = 16;
    localparam int unsigned RATE_W         = 16;
    localparam int unsigned TIME_W         = 16;
    localparam int unsigned IDX_W          = 4;
    localparam int unsigned SEL_W          = 3;
    localparam int unsigned ENTRY_W        = TIME_W + RATE_W;
    localparam int unsigned TBL_ADDR_W     = 7;
    // register map, byte addresses
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_RATE      = 12'h004;
    localparam logic [11:0] ADDR_SLEEP     = 12'h008;
    localparam logic [11:0] ADDR_RESET     = 12'h00c;
    localparam logic [11:0] ADDR_STATUS    = 12'h010;
    localparam logic [11:0] ADDR_CUR_RATE  = 12'h014;
    localparam logic [11:0] ADDR_TBL_ADDR  = 12'h018;
    localparam logic [11:0] ADDR_TBL_DATA  = 12'h01c;
    // control register fields
    localparam int unsigned CTRL_RES_LSB   = 0;
    localparam int unsigned CTRL_DEC_LSB   = 2;
    localparam int unsigned CTRL_PROF_LSB  = 4;
    localparam int unsigned CTRL_MODE_LSB  = 8;
    localparam int unsigned CTRL_DIR_BIT   = 12;
    // resolution codes
    localparam logic [1:0] RES_WHOLE       = 2'h0;
    localparam logic [1:0] RES_TWO         = 2'h1;
    localparam logic [1:0] RES_FOUR        = 2'h2;
    localparam logic [1:0] RES_SIXTEEN     = 2'h3;
    // decay codes
    localparam logic [1:0] DEC_SLOW        = 2'h0;
    localparam logic [1:0] DEC_FAST        = 2'h1;
    localparam logic [1:0] DEC_MIXED       = 2'h2;
    localparam logic [SEL_W-1:0] RAMP_NONE = 3'h0;
    localparam logic [3:0] MODE_STOPPED    = 4'h1;
    localparam logic [3:0] MODE_RUNNING    = 4'h2;
    // boolean thresholds, signed 16.16 fixed point: off 0.0, on 1.0
    localparam logic signed [31:0] BOOL_OFF_TH = 32'sh0000_0000;
    localparam logic signed [31:0] BOOL_ON_TH  = 32'sh0001_0000;
    typedef enum logic [1:0] {SPD_IDLE, SPD_ACCEL, SPD_RUN, SPD_DECEL} spd_state_type;
endpackage

// ===== tb/spd_drv_model.sv
// behavioural model of the bridge driver chip: microstep position and home tracking
`timescale 1ns/1ps
`default_nettype none
module spd_drv_model (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        drv_enable_n,
    input  wire logic        drv_reset_n,
    input  wire logic        drv_dir,
    input  wire logic [15:0] step_rate,
    output var  logic        at_home
);
    logic [5:0] pos_reg;
    // one microstep per clock while enabled with a nonzero step rate; coarse, but enough to leave home
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pos_reg <= 6'h00;
        end else if (!drv_reset_n) begin
            pos_reg <= 6'h00;
        end else if (!drv_enable_n && step_rate != 16'h0000) begin
            pos_reg <= drv_dir ? pos_reg + 6'h01 : pos_reg - 6'h01;
        end
    end
    assign at_home = (pos_reg == 6'h00);
endmodule
`default_nettype wire

// ===== tb/stepper_profile_and_drive_control_tb_top.sv
// self-checking bench for the stepper profile and drive control core
`timescale 1ns/1ps
`default_nettype none
module stepper_profile_and_drive_control_tb_top;
    import spd_pkg::*;
    localparam int TD = 10;
    typedef struct {logic [31:0] ctrl; logic [1:0] res; logic [1:0] dec;} spd_row_type;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, en_n, sl_n, rs_n, dir, home;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [1:0] res_sel, dec;
    logic [RATE_W-1:0] rate;
    logic err;
    int n_mismatch = 0;
    int cmp_count = 0;
    spd_row_type rows [5];
    int vel [16] = '{0, 15, 25, 33, 40, 46, 51, 55, 58, 60, 62, 63, 64, 65, 65, 65};
    ////////////////////////////////////////////////////////////////////////////
    spd_core #(.TICK_DIV(TD)) uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .res_sel(res_sel), .decay_select_level(dec), .drv_enable_n(en_n),
        .drv_sleep_n(sl_n), .drv_reset_n(rs_n), .drv_dir(dir), .step_rate(rate));
    spd_drv_model chip (.mclk(mclk), .resetn(resetn), .drv_enable_n(en_n), .drv_reset_n(rs_n),
        .drv_dir(dir), .step_rate(rate), .at_home(home));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // apb master: hold the request until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // dir set, sixteenth step and mixed decay kept so ctrl writes leave them alone
    function automatic logic [31:0] ctrl(input logic [3:0] m, input logic [2:0] p);
        return 32'h0000_100b | {20'h00000, m, 1'b0, p, 4'h0};
    endfunction
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (1000 * TD) @(posedge mclk);
        n_mismatch++;
        test_done;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rows = '{'{32'h1100, 2'h0, 2'h0}, '{32'h1105, 2'h1, 2'h1}, '{32'h110a, 2'h2, 2'h2},
                 '{32'h110f, 2'h3, 2'h2}, '{32'h1103, 2'h3, 2'h0}};
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        check("res_sel", 2'h3, res_sel);
        check("decay", 2'h2, dec);
        check("rate", 0, rate);
        check("sleep_n", 1, sl_n);
        xfer(1'b0, ADDR_CTRL, 32'h0);
        check("ramp off", 0, rdv[CTRL_PROF_LSB+:3]);
        foreach (rows[i]) begin
            wr(ADDR_CTRL, rows[i].ctrl);
            settle(2);
            check("res_sel", rows[i].res, res_sel);
            check("decay", rows[i].dec, dec);
        end
        wr(ADDR_RATE, 32'd100);
        wr(ADDR_CTRL, ctrl(MODE_RUNNING, RAMP_NONE));
        settle(3);
        check("jump start", 100, rate);
        wr(ADDR_CTRL, ctrl(MODE_STOPPED, RAMP_NONE));
        settle(3);
        check("jump stop", 0, rate);
        wr(ADDR_TBL_ADDR, 32'h0);
        for (int i = 0; i < 16; i++) wr(ADDR_TBL_DATA, {16'(i * 10), 16'(vel[i])});
        wr(ADDR_RATE, 32'd48);
        wr(ADDR_CTRL, ctrl(MODE_RUNNING, 3'h1));
        settle(55 * TD);
        check("accel 55ms", 46, rate);
        settle(10 * TD);
        check("accel cap", 48, rate);
        wr(ADDR_RATE, 32'd70);
        settle(3);
        check("run change", 70, rate);
        wr(ADDR_CTRL, ctrl(MODE_STOPPED, 3'h1));
        settle(20);
        check("overspeed drop", 65, rate);
        settle(170 * TD);
        check("decel end", 0, rate);
        wr(ADDR_RATE, 32'd48);
        wr(ADDR_CTRL, ctrl(MODE_RUNNING, 3'h1));
        settle(70 * TD);
        wr(ADDR_CTRL, ctrl(MODE_STOPPED, 3'h1));
        settle(5 * TD);
        check("decel from rate", 48, rate);
        settle(60 * TD);
        check("decel 60ms", 0, rate);
        wr(ADDR_RATE, 32'd100);
        wr(ADDR_CTRL, ctrl(MODE_RUNNING, RAMP_NONE));
        wr(ADDR_SLEEP, 32'h0001_0000);
        settle(3);
        check("sleep_n", 0, sl_n);
        check("enable_n", 1, en_n);
        wr(ADDR_SLEEP, 32'h0000_8000);
        settle(3);
        check("sleep held", 0, sl_n);
        wr(ADDR_SLEEP, 32'h0000_0000);
        settle(3);
        check("sleep_n", 1, sl_n);
        check("still off", 1, en_n);
        wr(ADDR_RATE, 32'd120);
        settle(3);
        check("wake enable", 0, en_n);
        check("wake rate", 120, rate);
        wr(ADDR_RESET, 32'h0002_0000);
        settle(3);
        check("reset_n", 0, rs_n);
        check("enable_n", 1, en_n);
        check("rate", 0, rate);
        check("home", 1, home);
        wr(ADDR_RESET, 32'hffff_0000);
        settle(3);
        check("reset_n", 1, rs_n);
        check("still off", 1, en_n);
        wr(ADDR_CTRL, ctrl(MODE_STOPPED, RAMP_NONE));
        wr(ADDR_CTRL, ctrl(MODE_RUNNING, RAMP_NONE));
        settle(3);
        check("reenable", 0, en_n);
        xfer(1'b0, 12'h020, 32'h0);
        check("unmapped err", 1, err);
        xfer(1'b0, 12'h002, 32'h0);
        check("misaligned err", 1, err);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        check("status err", 0, err);
        check("status", 32'h0000_0002, rdv);
        xfer(1'b0, ADDR_CUR_RATE, 32'h0);
        check("present rate", 120, rdv);
        @(posedge mclk);
        resetn <= 1'b0;
        settle(2);
        check("res_sel", 2'h3, res_sel);
        check("rate", 0, rate);
        @(posedge mclk);
        resetn <= 1'b1;
        settle(2);
        check("rate", 0, rate);
        test_done;
    end
endmodule
`default_nettype wire
